// ---- grf_pkg.sv ----
// How it works
// (R1) manual mode uses the selected reference input
// (R2) bi-level and tri-level sync both accepted
// (R3) termination enable output follows configuration bit
// (R4) report standard, unknown or not-present
// (R5) output reference: none, or source plus lock
// (R6) lock state: locked, locking, unlocked
// (R7) program video never used as reference
// (R8) auto mode picks highest qualified input
// (R9) three priority slots, used in order
// (R10) valid after programmable 0..300 consecutive frames
// (R11) absent after programmable 0..100 missing frames
// (R12) fail-over status names locked input or none
// (R13) fail-over reset rescans from first slot
// (R14) time code from two lines, either valid
// (R15) last time code readable
// (R16) each trap gated by its own enable
// (R17) genlock-present trap when reference lost
// (R18) per program input phase-lock loss trap
// (R19) event on every fail-over reference change
// (R20) auto off: manual source only, no switching
package grf_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_PRIO    = 8'h04;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h08;
    localparam logic [7:0] ADDR_VITCLN  = 8'h0C;
    localparam logic [7:0] ADDR_RESET   = 8'h10;
    localparam logic [7:0] ADDR_STATUS  = 8'h14;
    localparam logic [7:0] ADDR_VITC    = 8'h18;
    localparam logic [7:0] ADDR_TRAP    = 8'h1C;

    // ctrl fields
    localparam int CTRL_SRC_LSB   = 0;
    localparam int CTRL_TERM_BIT  = 2;
    localparam int CTRL_AUTO_BIT  = 3;
    localparam int CTRL_TEN_LSB   = 4;   // 4 trap enables: present, pgm a, pgm b, event
    localparam int TIMEOUT_INV_LSB = 16;
    localparam int VITCLN_L2_LSB  = 16;

    localparam logic [8:0]  VALID_TO_MAX   = 9'd300;
    localparam logic [6:0]  INVALID_TO_MAX = 7'd100;
    localparam logic [10:0] VITC_LINE1_RST = 11'd14;
    localparam logic [10:0] VITC_LINE2_RST = 11'd16;
    localparam logic [1:0]  AXI_OKAY       = 2'b00;
    localparam logic [1:0]  AXI_SLVERR     = 2'b10;

    // reference input codes; 3 means none
    typedef enum logic [1:0] {
        GRF_REF_CARD  = 2'b00,
        GRF_REF_SHLF1 = 2'b01,
        GRF_REF_SHLF2 = 2'b10,
        GRF_REF_NONE  = 2'b11
    } grf_ref_t;

    typedef enum logic [1:0] {
        GRF_LK_UNLOCKED = 2'b00,
        GRF_LK_LOCKING  = 2'b01,
        GRF_LK_LOCKED   = 2'b10
    } grf_lock_t;

    // standard code: 0 = not present, 1F = unknown, else detected code
    localparam logic [4:0] STD_NOT_PRESENT = 5'h00;
    localparam logic [4:0] STD_UNKNOWN     = 5'h1F;

    // per reference input measurement from the sync separator
    typedef struct packed {
        logic       present;
        logic       std_known;
        logic [4:0] std_code;
        logic       tri_level;
    } grf_refin_t;

    typedef struct packed {
        logic        line_strobe;
        logic [10:0] line_num;
        logic        ok;
        logic [31:0] code;
    } grf_vitc_t;

    typedef struct packed {
        logic present;
        logic pgm_a;
        logic pgm_b;
        logic event_chg;
    } grf_traps_t;

endpackage : grf_pkg

// ---- grf_top.sv ----
`timescale 1ns/100ps
module grf_top (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    // axi4-lite slave
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // reference inputs: card, shelf 1, shelf 2; frame tick, pll lock, program phase, time code
    input  wire logic                   frame_tick,
    input  wire grf_pkg::grf_refin_t    ref_in [3],
    input  wire logic                   pll_locked,
    input  wire logic [1:0]             program_input_pair_phase_ok,
    input  wire grf_pkg::grf_vitc_t     vitc_in,
    // timing generator side
    output grf_pkg::grf_ref_t           ref_sel,
    output logic                        term_en,
    output grf_pkg::grf_traps_t         trap_pulse,
    output logic [1:0]                  trap_ref_code
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] ctrl;
        logic [5:0]  prio;
        logic [8:0]  valid_to;
        logic [6:0]  invalid_to;
        logic [10:0] vline1;
        logic [10:0] vline2;
        logic [8:0]  vcnt0;
        logic [8:0]  vcnt1;
        logic [8:0]  vcnt2;
        logic [6:0]  icnt0;
        logic [6:0]  icnt1;
        logic [6:0]  icnt2;
        logic [2:0]  qual;
        logic        rescan;
        grf_pkg::grf_ref_t sel;
        logic [31:0] vitc;
        logic        vitc_valid;
        logic [1:0]  phase_q;
        logic        pres_q;
        grf_pkg::grf_traps_t traps;
        logic [1:0]  trap_code;
        logic        term;
    } grf_state_t;

    grf_state_t st;
    grf_state_t next_st;

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : apply_strb

    function automatic logic is_mapped(input logic [7:0] a);
        return (a <= grf_pkg::ADDR_TRAP) && (a[1:0] == 2'b00);
    endfunction : is_mapped

    // qualifier step for one input: returns new {qual, vcnt, icnt}
    function automatic logic [16:0] qualify(input logic q, input logic pres,
                                            input logic [8:0] vc, input logic [6:0] ic,
                                            input logic [8:0] vto, input logic [6:0] ito);
        logic       nq;
        logic [8:0] nvc;
        logic [6:0] nic;
        nq  = q;
        nvc = vc;
        nic = ic;
        if (pres) begin
            nic = 7'd0;
            if (!q) begin
                if (vc >= vto) begin                         // [R10]
                    nq  = 1'b1;
                    nvc = 9'd0;
                end else begin
                    nvc = vc + 9'd1;
                end
            end
        end else begin
            nvc = 9'd0;
            if (q) begin
                if (ic >= ito) begin                         // [R11]
                    nq  = 1'b0;
                    nic = 7'd0;
                end else begin
                    nic = ic + 7'd1;
                end
            end
        end
        return {nq, nvc, nic};
    endfunction : qualify

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [16:0]        qr [3];
    logic [2:0]         qnew;
    grf_pkg::grf_ref_t  pick;
    grf_pkg::grf_ref_t  msrc;
    grf_pkg::grf_lock_t lk;
    logic [4:0]         stdc;
    logic               cur_pres;
    logic [31:0]        rd;

    always_comb begin
        next_st = st;
        next_st.traps = '0;
        msrc = grf_pkg::grf_ref_t'({1'b0, st.ctrl[grf_pkg::CTRL_SRC_LSB]} |
                                   {st.ctrl[grf_pkg::CTRL_SRC_LSB + 1], 1'b0});
        if (msrc == grf_pkg::GRF_REF_NONE) begin
            msrc = grf_pkg::GRF_REF_CARD;
        end
        // write channel
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got  = 1'b1;
            next_st.awready = 1'b0;
            next_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got  = 1'b1;
            next_st.wready = 1'b0;
            next_st.wdata  = s_axi_wdata;
            next_st.wstrb  = s_axi_wstrb;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.bvalid = 1'b1;
            next_st.bresp  = is_mapped(st.awaddr) ? grf_pkg::AXI_OKAY : grf_pkg::AXI_SLVERR;
            if (st.awaddr == grf_pkg::ADDR_CTRL) begin
                next_st.ctrl = apply_strb(st.ctrl, st.wdata, st.wstrb);
            end else if (st.awaddr == grf_pkg::ADDR_PRIO) begin
                next_st.prio = 6'(apply_strb({26'd0, st.prio}, st.wdata, st.wstrb));
            end else if (st.awaddr == grf_pkg::ADDR_TIMEOUT) begin
                next_st.valid_to = (st.wdata[8:0] > grf_pkg::VALID_TO_MAX) ?
                                   grf_pkg::VALID_TO_MAX : st.wdata[8:0];
                next_st.invalid_to = (st.wdata[grf_pkg::TIMEOUT_INV_LSB +: 7] >
                                      grf_pkg::INVALID_TO_MAX) ? grf_pkg::INVALID_TO_MAX :
                                     st.wdata[grf_pkg::TIMEOUT_INV_LSB +: 7];
            end else if (st.awaddr == grf_pkg::ADDR_VITCLN) begin
                next_st.vline1 = st.wdata[10:0];
                next_st.vline2 = st.wdata[grf_pkg::VITCLN_L2_LSB +: 11];
            end else if (st.awaddr == grf_pkg::ADDR_RESET) begin
                next_st.rescan = 1'b1;                       // [R13]
            end
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid  = 1'b0;
            next_st.aw_got  = 1'b0;
            next_st.w_got   = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end
        // qualification per input, frame-clocked
        for (int i = 0; i < 3; i++) begin
            qr[i] = qualify(st.qual[i], ref_in[i].present,
                            (i == 0) ? st.vcnt0 : (i == 1) ? st.vcnt1 : st.vcnt2,
                            (i == 0) ? st.icnt0 : (i == 1) ? st.icnt1 : st.icnt2,
                            st.valid_to, st.invalid_to);
            qnew[i] = qr[i][16];
        end
        // any sync type counts as present [R2]
        if (frame_tick) begin
            next_st.qual  = qnew;
            next_st.vcnt0 = qr[0][15:7];
            next_st.vcnt1 = qr[1][15:7];
            next_st.vcnt2 = qr[2][15:7];
            next_st.icnt0 = qr[0][6:0];
            next_st.icnt1 = qr[1][6:0];
            next_st.icnt2 = qr[2][6:0];
        end
        // selection: only reference inputs are candidates [R7]
        pick = grf_pkg::GRF_REF_NONE;
        for (int s = 2; s >= 0; s--) begin
            if (st.prio[s*2 +: 2] != 2'b11 && st.qual[st.prio[s*2 +: 2]]) begin
                pick = grf_pkg::grf_ref_t'(st.prio[s*2 +: 2]);   // [R8] [R9]
            end
        end
        if (!st.ctrl[grf_pkg::CTRL_AUTO_BIT]) begin
            next_st.sel = msrc;                              // [R1] [R20]
        end else if (st.rescan || st.sel == grf_pkg::GRF_REF_NONE ||
                     !st.qual[st.sel] || pick != st.sel) begin
            next_st.sel = pick;
        end
        next_st.rescan = (st.awaddr == grf_pkg::ADDR_RESET) && st.aw_got && st.w_got &&
                         !st.bvalid;
        if (next_st.sel != st.sel && st.ctrl[grf_pkg::CTRL_AUTO_BIT] &&
            st.ctrl[grf_pkg::CTRL_TEN_LSB + 3]) begin
            next_st.traps.event_chg = 1'b1;                  // [R19] [R16]
            next_st.trap_code = next_st.sel;
        end
        // time code: either line good gives a reading
        if (vitc_in.line_strobe && vitc_in.ok &&
            (vitc_in.line_num == st.vline1 || vitc_in.line_num == st.vline2)) begin
            next_st.vitc       = vitc_in.code;               // [R14] [R15]
            next_st.vitc_valid = 1'b1;
        end
        // traps on falling edges of condition
        cur_pres = (st.sel != grf_pkg::GRF_REF_NONE) && ref_in[st.sel].present;
        next_st.pres_q  = cur_pres;
        next_st.phase_q = program_input_pair_phase_ok;
        next_st.traps.present = st.pres_q && !cur_pres &&
                                st.ctrl[grf_pkg::CTRL_TEN_LSB];            // [R17] [R16]
        next_st.traps.pgm_a = st.phase_q[0] && !program_input_pair_phase_ok[0] &&
                              st.ctrl[grf_pkg::CTRL_TEN_LSB + 1];          // [R18]
        next_st.traps.pgm_b = st.phase_q[1] && !program_input_pair_phase_ok[1] &&
                              st.ctrl[grf_pkg::CTRL_TEN_LSB + 2];          // [R18]
        next_st.term = st.ctrl[grf_pkg::CTRL_TERM_BIT];                    // [R3]
        // status word
        stdc = grf_pkg::STD_NOT_PRESENT;
        if (cur_pres) begin
            stdc = ref_in[st.sel].std_known ? ref_in[st.sel].std_code :
                   grf_pkg::STD_UNKNOWN;                                   // [R4]
        end
        if (!cur_pres || !st.qual[st.sel]) begin
            lk = grf_pkg::GRF_LK_UNLOCKED;                                 // [R6]
        end else if (pll_locked) begin
            lk = grf_pkg::GRF_LK_LOCKED;
        end else begin
            lk = grf_pkg::GRF_LK_LOCKING;
        end
        // read channel
        rd = 32'h0000_0000;
        if (st.arready == 1'b0 && st.rvalid && s_axi_rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end
        if (s_axi_arvalid && st.arready) begin
            if (s_axi_araddr == grf_pkg::ADDR_CTRL) begin
                rd = st.ctrl;
            end else if (s_axi_araddr == grf_pkg::ADDR_PRIO) begin
                rd = {26'd0, st.prio};
            end else if (s_axi_araddr == grf_pkg::ADDR_TIMEOUT) begin
                rd = {9'd0, st.invalid_to, 7'd0, st.valid_to};
            end else if (s_axi_araddr == grf_pkg::ADDR_VITCLN) begin
                rd = {5'd0, st.vline2, 5'd0, st.vline1};
            end else if (s_axi_araddr == grf_pkg::ADDR_STATUS) begin
                // [R5] [R12] source field none when no input is qualified; locked field none unless locked
                rd = {st.vitc_valid, 14'd0, ref_in[0].tri_level, 2'd0, st.qual, stdc,
                      lk, (st.qual == 3'b000) ? grf_pkg::GRF_REF_NONE : st.sel,
                      (lk == grf_pkg::GRF_LK_LOCKED) ? st.sel : grf_pkg::GRF_REF_NONE};
            end else if (s_axi_araddr == grf_pkg::ADDR_VITC) begin
                rd = st.vitc;
            end
            next_st.arready = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rdata   = rd;
            next_st.rresp   = is_mapped(s_axi_araddr) ? grf_pkg::AXI_OKAY : grf_pkg::AXI_SLVERR;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st            <= '0;
            st.awready    <= 1'b1;
            st.wready     <= 1'b1;
            st.arready    <= 1'b1;
            st.prio       <= 6'h24;
            st.valid_to   <= 9'd0;
            st.invalid_to <= 7'd0;
            st.vline1     <= grf_pkg::VITC_LINE1_RST;
            st.vline2     <= grf_pkg::VITC_LINE2_RST;
            st.sel        <= grf_pkg::GRF_REF_CARD;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = st.awready;
    assign s_axi_wready  = st.wready;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign ref_sel       = st.sel;
    assign term_en       = st.term;
    assign trap_pulse    = st.traps;
    assign trap_ref_code = st.trap_code;

endmodule : grf_top

// ---- grf_top_checker.sv ----
`timescale 1ns/100ps
module grf_top_checker (
    // clock and reset
    input wire logic                core_clk,
    input wire logic                rstn,
    // register bus
    input wire logic [7:0]          s_axi_awaddr,
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic [31:0]         s_axi_wdata,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic [1:0]          s_axi_bresp,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic [1:0]          s_axi_rresp,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    // timing generator side
    input wire logic                term_en,
    input wire grf_pkg::grf_traps_t trap_pulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------
    // control mirror: taken when a write to it is answered
    // ------------------------------------------------------------
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [31:0] ctrl;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wa   <= 8'h00;
            wd   <= 32'h0;
            ctrl <= 32'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
            if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 && wa == 8'h00) ctrl <= wd;
        end
    end
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence settled;
        !s_axi_bvalid && !$past(s_axi_bvalid);
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    b_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    b_hold_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
        else $error("write answer dropped early");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    r_hold_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
        else $error("read answer dropped early");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    term_follow_a: assert property (settled |-> term_en == ctrl[2])
        else $error("termination enable wrong");
    trap_gate_a: assert property (!(trap_pulse.present && !ctrl[4]))
        else $error("present trap while disabled");
    pgm_gate_a: assert property (!(trap_pulse.pgm_a && !ctrl[5]) &&
        !(trap_pulse.pgm_b && !ctrl[6]))
        else $error("phase trap while disabled");
    event_gate_a: assert property (!(trap_pulse.event_chg && !ctrl[7]))
        else $error("event trap while disabled");
endmodule : grf_top_checker

bind grf_top grf_top_checker grf_top_checker_i (.*);

// ---- grf_ref_gen.sv ----
`timescale 1ns/100ps
module grf_ref_gen #(
    parameter logic [4:0] STD = 5'h05
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rstn,
    // scenario control
    input  wire logic [2:0]    ref_on,
    input  wire logic [2:0]    std_ok,
    // reference side
    output logic               frame_tick,
    output grf_pkg::grf_refin_t ref_in [3]
);
    logic [3:0] cnt;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt        <= 4'h0;
            frame_tick <= 1'h0;
        end else begin
            cnt        <= cnt + 4'h1;
            frame_tick <= (cnt == 4'hF);
        end
    end
    // card is tri-level, shelves bi-level; a lost input shows a moving pattern
    for (genvar i = 0; i < 3; i++) begin : g_in
        assign ref_in[i] = {ref_on[i], ref_on[i] & std_ok[i],
                            ref_on[i] ? STD : {cnt, cnt[0]},
                            ref_on[i] ? (i == 0) : cnt[1]};
    end
endmodule : grf_ref_gen

// ---- genlock_reference_failover_bench.sv ----
`timescale 1ns/100ps
module genlock_reference_failover_bench;
    logic                core_clk = 1'h0;
    logic                rstn = 1'h0;
    logic [7:0]          s_axi_awaddr = 8'h00;
    logic [7:0]          s_axi_araddr = 8'h00;
    logic [31:0]         s_axi_wdata = 32'h0;
    logic                s_axi_awvalid = 1'h0;
    logic                s_axi_wvalid = 1'h0;
    logic                s_axi_bready = 1'h0;
    logic                s_axi_arvalid = 1'h0;
    logic                s_axi_rready = 1'h0;
    logic                s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]          s_axi_bresp, s_axi_rresp, rs;
    logic [31:0]         s_axi_rdata, rdv;
    logic                frame_tick, term_en;
    logic                pll_locked = 1'h0;
    logic [1:0]          phase_ok = 2'h3;
    logic [2:0]          ref_on = 3'h7;
    logic [2:0]          std_ok = 3'h7;
    logic [3:0]          seen = 4'h0;
    logic                clr_seen = 1'h0;
    logic [1:0]          trap_ref_code;
    grf_pkg::grf_refin_t ref_in [3];
    grf_pkg::grf_vitc_t  vitc_in = '0;
    grf_pkg::grf_ref_t   ref_sel;
    grf_pkg::grf_traps_t trap_pulse;
    int                  fail_count = 0;
    int                  checked = 0;

    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) seen <= clr_seen ? 4'h0 : seen | trap_pulse;

    grf_ref_gen grf_ref_gen_i (.*);
    grf_top grf_top_i (.*, .s_axi_wstrb(4'hF), .program_input_pair_phase_ok(phase_ok));

    task automatic complete_run();
        if (fail_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic tick(inout int n);
        @(posedge core_clk);
        n++;
        if (n > 5000) begin
            fail_count++;
            complete_run();
        end
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            tick(n);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            tick(n);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : rd
    task automatic frames(input int f);
        int n;
        n = 0;
        while (f > 0) begin
            tick(n);
            if (frame_tick) f--;
        end
    endtask : frames
    task automatic clr();
        clr_seen <= 1'h1;
        @(posedge core_clk);
        clr_seen <= 1'h0;
    endtask : clr

    task automatic t_regs();
        check(32'(ref_sel), 32'h0);
        rd(8'h04, rdv, rs);
        check(rdv, 32'h24);
        rd(8'h0C, rdv, rs);
        check(rdv, 32'h0010_000E);
        rd(8'h40, rdv, rs);
        check(rdv, 32'h0);
        check(32'(rs), 32'h2);
        wr(8'h44, 32'h0000_00FF, rs);
        check(32'(rs), 32'h2);
    endtask : t_regs
    task automatic t_manual();
        logic [1:0] s;
        for (int i = 0; i < 3; i++) begin
            s = 2'(i);
            wr(8'h00, {29'h0, s[0], s}, rs);
            frames(1);
            check(32'(ref_sel), 32'(s));
            check(32'(term_en), 32'(s[0]));
            ref_on <= ~(3'h1 << s);
            frames(3);
            check(32'(ref_sel), 32'(s));
            ref_on <= 3'h7;
        end
    endtask : t_manual
    task automatic t_std();
        wr(8'h08, 32'h0001_0002, rs);
        wr(8'h00, 32'h0, rs);
        frames(4);
        rd(8'h14, rdv, rs);
        check(32'(rdv[10:6]), 32'h05);
        check(32'(rdv[16]), 32'h1);
        std_ok <= 3'h6;
        frames(2);
        rd(8'h14, rdv, rs);
        check(32'(rdv[10:6]), 32'h1F);
        ref_on <= 3'h6;
        frames(4);
        rd(8'h14, rdv, rs);
        check(32'(rdv[10:6]), 32'h00);
        ref_on <= 3'h7;
        std_ok <= 3'h7;
    endtask : t_std
    task automatic t_auto();
        wr(8'h00, 32'h0000_00F8, rs);
        pll_locked <= 1'h1;
        frames(4);
        rd(8'h14, rdv, rs);
        check(32'(ref_sel), 32'h0);
        check(32'(rdv[5:0]), 32'h20);
        clr();
        ref_on <= 3'h6;
        frames(1);
        check(32'(ref_sel), 32'h0);
        frames(2);
        check(32'(ref_sel), 32'h1);
        check(32'(seen), 32'h9);
        check(32'(trap_ref_code), 32'h1);
        ref_on <= 3'h7;
        frames(2);
        check(32'(ref_sel), 32'h1);
        frames(2);
        check(32'(ref_sel), 32'h0);
        pll_locked <= 1'h0;
        frames(1);
        rd(8'h14, rdv, rs);
        check(32'(rdv[5:4]), 32'h1);
        ref_on <= 3'h0;
        frames(3);
        rd(8'h14, rdv, rs);
        check(32'(ref_sel), 32'h3);
        check(32'(rdv[5:0]), 32'h0F);
        ref_on <= 3'h7;
        pll_locked <= 1'h1;
        wr(8'h04, 32'h06, rs);
        wr(8'h10, 32'h1, rs);
        frames(5);
        check(32'(ref_sel), 32'h2);
    endtask : t_auto
    task automatic t_gate();
        wr(8'h04, 32'h24, rs);
        wr(8'h00, 32'h28, rs);
        frames(4);
        clr();
        phase_ok <= 2'h2;
        ref_on <= 3'h6;
        frames(4);
        check(32'(seen), 32'h4);
        wr(8'h00, 32'h48, rs);
        phase_ok <= 2'h3;
        clr();
        phase_ok <= 2'h0;
        frames(2);
        check(32'(seen), 32'h2);
        phase_ok <= 2'h3;
        ref_on <= 3'h7;
    endtask : t_gate
    task automatic t_vitc();
        @(posedge core_clk);
        vitc_in <= '{1'h1, 11'h00E, 1'h0, 32'hDEAD_0000};
        @(posedge core_clk);
        vitc_in <= '{1'h1, 11'h010, 1'h1, 32'h1234_5678};
        @(posedge core_clk);
        vitc_in <= '0;
        rd(8'h18, rdv, rs);
        check(rdv, 32'h1234_5678);
        rd(8'h14, rdv, rs);
        check(32'(rdv[31]), 32'h1);
    endtask : t_vitc

    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'h1;
        t_regs();
        t_manual();
        t_std();
        t_auto();
        t_gate();
        t_vitc();
        complete_run();
    end
endmodule : genlock_reference_failover_bench
